// File: shared/rst_seq_pkg.sv
// constants for the reset and power sequencer
package rst_seq_pkg;
    localparam int CLK_HZ = 10_000_000;
    // flash wake-up time, microseconds, least time: clock MHz truncated, at least 1 cycle
    localparam int FLASH_WAKE_US = 100;
    localparam int FLASH_WAKE_CYC = (FLASH_WAKE_US * (CLK_HZ / 1_000_000) + 0) > 0 ?
        FLASH_WAKE_US * (CLK_HZ / 1_000_000) : 1;
    // fixed clock count after oscillator runs
    localparam int FIXED_CLK_CNT = 16;
    localparam int CNT_W = 12;
    localparam logic [31:0] BOOT_VECTOR = 32'h0000_0000;
    localparam int NUM_EINT = 4;
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN = 2'b11,
        ST_DPD = 2'b10
    } seq_state_t;
endpackage

// File: hw/reset_brownout_power_seq.sv
// reset merging, brownout and deep power-down sequencer
// Operation
// - deep power-down exit equals full chip reset
// - deep power-down wakes on alarm or reset pin
// - supply return after loss starts normal startup
// - battery RAM retention is left to its domain
// - reset from pin, watchdog, power-on, brownout
// - hold reset until pin, oscillator, count, flash
// - first fetch address is zero after release
// - registers reset while internal reset asserted
// - upper brownout stage raises interrupt request
// - interrupt gated by enable, level readable
// - lower brownout stage forces chip reset
// - brownout reset held, power-on below one volt
// - both brownout comparisons use hysteresis
// - enabled external interrupts wake from power-down
// - alarm output drives external power restore
// - run from internal RC oscillator after reset
// - flash blocked for wake-up time after wake
`timescale 1ns/1ps
`default_nettype none
module reset_brownout_power_seq
    import rst_seq_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // reset sources
    input wire logic ext_reset_n,
    input wire logic watchdog_timer_rst,
    input wire logic por_active,
    // supply comparators, raw analog outputs
    input wire logic vdd_below_upper,
    input wire logic vdd_above_upper_hys,
    input wire logic vdd_below_lower,
    input wire logic vdd_above_lower_hys,
    // oscillator and flash status
    input wire logic osc_running,
    input wire logic flash_init_done,
    // power control
    input wire logic dpd_request,
    input wire logic pd_active,
    input wire logic rtc_alarm,
    input wire logic [NUM_EINT-1:0] eint_in,
    input wire logic [NUM_EINT-1:0] eint_wake_en,
    input wire logic bod_irq_enable,
    // outputs
    output logic internal_rst,
    output logic [31:0] fetch_addr,
    output logic use_internal_rc_oscillator,
    output logic brownout_detector_irq,
    output logic brownout_detector_status,
    output logic flash_access_ok,
    output logic regulator_on,
    output logic pd_wake,
    output logic rtc_alarm_out
);
    seq_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [2:0] ext_s_r, wdt_s_r, por_s_r, alarm_s_r;
    logic [2:0] up_lo_s_r, up_hi_s_r, lw_lo_s_r, lw_hi_s_r;
    logic [NUM_EINT-1:0] eint_s0_r, eint_s1_r, eint_s2_r;
    logic bod_irq_r, bod_rst_r, ext_f_r, wdt_f_r, por_f_r, alarm_f_r;
    logic [CNT_W-1:0] flash_cnt_r;
    logic flash_ok_r, rst_r;

    // three-stage sampling; a level counts once stages 2 and 3 agree
    always_ff @(posedge core_clk)
    begin
        ext_s_r <= {ext_s_r[1:0], ext_reset_n};
        wdt_s_r <= {wdt_s_r[1:0], watchdog_timer_rst};
        por_s_r <= {por_s_r[1:0], por_active};
        alarm_s_r <= {alarm_s_r[1:0], rtc_alarm};
        up_lo_s_r <= {up_lo_s_r[1:0], vdd_below_upper};
        up_hi_s_r <= {up_hi_s_r[1:0], vdd_above_upper_hys};
        lw_lo_s_r <= {lw_lo_s_r[1:0], vdd_below_lower};
        lw_hi_s_r <= {lw_hi_s_r[1:0], vdd_above_lower_hys};
        eint_s0_r <= eint_in;
        eint_s1_r <= eint_s0_r;
        eint_s2_r <= eint_s1_r;
    end

    wire ext_ag = ext_s_r[1] == ext_s_r[2];
    wire wdt_ag = wdt_s_r[1] == wdt_s_r[2];
    wire por_ag = por_s_r[1] == por_s_r[2];
    wire al_ag = alarm_s_r[1] == alarm_s_r[2];
    wire [NUM_EINT-1:0] eint_ag = ~(eint_s1_r ^ eint_s2_r);

    // filtered levels; a disagreement keeps the old value
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ext_f_r <= 1'b0;
            wdt_f_r <= 1'b0;
            por_f_r <= 1'b1;
            alarm_f_r <= 1'b0;
        end
        else
        begin
            if (ext_ag) ext_f_r <= ~ext_s_r[2];
            if (wdt_ag) wdt_f_r <= wdt_s_r[2];
            if (por_ag) por_f_r <= por_s_r[2];
            if (al_ag) alarm_f_r <= alarm_s_r[2];
        end
    end

    // hysteresis: set below threshold, clear only above the upper band
    wire up_set = up_lo_s_r[1] & up_lo_s_r[2];
    wire up_clr = up_hi_s_r[1] & up_hi_s_r[2];
    wire lw_set = lw_lo_s_r[1] & lw_lo_s_r[2];
    wire lw_clr = lw_hi_s_r[1] & lw_hi_s_r[2];
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            bod_irq_r <= 1'b0;
            bod_rst_r <= 1'b0;
        end
        else
        begin
            // set wins over clear when both comparators are on
            bod_irq_r <= up_set | (bod_irq_r & ~up_clr);
            bod_rst_r <= lw_set | (bod_rst_r & ~lw_clr);
        end
    end

    assign brownout_detector_status = bod_irq_r;
    assign brownout_detector_irq = bod_irq_r & bod_irq_enable;

    // any source forces reset; por covers supply below brownout range
    wire any_src = ext_f_r | wdt_f_r | por_f_r | bod_rst_r;
    wire dpd_wake = alarm_f_r | ext_f_r;
    wire ready_all = ~ext_f_r & osc_running & flash_init_done;
    wire cnt_done = cnt_r == CNT_W'(FIXED_CLK_CNT);

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            ST_RESET:
            begin
                cnt_nxt = '0;
                if (!any_src)
                    state_nxt = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (osc_running && !cnt_done)
                    cnt_nxt = cnt_r + CNT_W'(1);
                if (any_src)
                    state_nxt = ST_RESET;
                else if (ready_all && cnt_done)
                    state_nxt = ST_RUN;
            end
            ST_RUN:
            begin
                if (any_src)
                    state_nxt = ST_RESET;
                else if (dpd_request)
                    state_nxt = ST_DPD;
            end
            ST_DPD:
            begin
                // no retention: leaving goes through a full reset
                if (dpd_wake || por_f_r)
                    state_nxt = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_r <= ST_RESET;
            cnt_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // assert at once on a source, release only from a clocked state
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            rst_r <= 1'b1;
        else
            rst_r <= state_nxt != ST_RUN;
    end
    assign internal_rst = rst_r | any_src | sys_rst;

    // flash wake-up counter after a power-down wake
    assign pd_wake = pd_active & |(eint_s2_r & eint_ag & eint_wake_en);
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || internal_rst || pd_active)
        begin
            flash_cnt_r <= '0;
            flash_ok_r <= 1'b0;
        end
        else if (flash_cnt_r == CNT_W'(FLASH_WAKE_CYC - 1))
            flash_ok_r <= 1'b1;
        else
            flash_cnt_r <= flash_cnt_r + CNT_W'(1);
    end
    // gate at once: the counter clears only on the next edge after a reset hits
    assign flash_access_ok = flash_ok_r & ~internal_rst;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            fetch_addr <= BOOT_VECTOR;
        else if (internal_rst)
            fetch_addr <= BOOT_VECTOR;
    end

    assign use_internal_rc_oscillator = 1'b1; // no clock switch logic here
    assign regulator_on = state_r != ST_DPD; // battery ram lives elsewhere
    assign rtc_alarm_out = alarm_f_r;
endmodule // reset_brownout_power_seq
`default_nettype wire

// File: sim/supply_model.sv
// supply monitor model: level code to comparator outputs
`timescale 1ns/1ps
`default_nettype none
module supply_model (
    // level: 0 good, 1 below upper, 2 below lower, 3 inside upper band
    input wire logic [1:0] lvl,
    // comparator outputs
    output logic b_up,
    output logic a_up,
    output logic b_lo,
    output logic a_lo
);
    // code 3 sits between threshold and clear level: neither upper-stage comparator on
    assign b_up = (lvl == 2'h1) || (lvl == 2'h2);
    assign a_up = (lvl == 2'h0);
    assign b_lo = (lvl == 2'h2);
    assign a_lo = (lvl != 2'h2);
endmodule // supply_model
`default_nettype wire

// File: sim/reset_brownout_power_seq_assertions.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module seq_chk (
    input wire logic core_clk, sys_rst, ext_reset_n, watchdog_timer_rst,
    input wire logic vdd_below_upper, vdd_below_lower, osc_running, flash_init_done,
    input wire logic rtc_alarm, internal_rst, use_internal_rc_oscillator,
    input wire logic brownout_detector_irq, brownout_detector_status, bod_irq_enable,
    input wire logic flash_access_ok, rtc_alarm_out,
    input wire logic [31:0] fetch_addr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence rel_s; $fell(internal_rst); endsequence
    pin_rst_a: assert property (!ext_reset_n [*5] |-> internal_rst) else $error("pin");
    wdt_rst_a: assert property (watchdog_timer_rst [*5] |-> internal_rst) else $error("wdt");
    low_bod_a: assert property (vdd_below_lower [*6] |-> internal_rst) else $error("bod");
    rel_cond_a: assert property (rel_s |-> osc_running && flash_init_done && ext_reset_n)
        else $error("release");
    boot_addr_a: assert property (rel_s |-> fetch_addr == 32'h0000_0000) else $error("addr");
    rc_clk_a: assert property (use_internal_rc_oscillator) else $error("rc");
    irq_gate_a: assert property (brownout_detector_irq == (brownout_detector_status
        && bod_irq_enable)) else $error("irq");
    up_bod_a: assert property (vdd_below_upper [*5] |-> brownout_detector_status)
        else $error("status");
    flash_blk_a: assert property (internal_rst |-> !flash_access_ok) else $error("flash");
    flash_wait_a: assert property (rel_s |-> !flash_access_ok [*8]) else $error("fwait");
    alarm_a: assert property (rtc_alarm [*5] |-> rtc_alarm_out) else $error("alarm");
endmodule // seq_chk
bind reset_brownout_power_seq seq_chk u_chk (.*);
`default_nettype wire

// File: sim/reset_brownout_power_seq_tb_top.sv
// testbench for the reset and power sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_brownout_power_seq_tb_top;
    import rst_seq_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, pin_n = 1'b1, wdt = 1'b0, por = 1'b0, osc = 1'b1;
    logic dpd = 1'b0, pd = 1'b0, alarm = 1'b0, irqen = 1'b0, irst, rc, irq, st, fok, ron, wk, aout;
    logic bu, au, bl, al, fl = 1'b1;
    logic [1:0] lvl = 2'h0;
    logic [NUM_EINT-1:0] eint = '0, een = '0;
    logic [31:0] fa;
    int bad_count = 0, n_tests = 0;
    always #50 core_clk = ~core_clk;
    supply_model sup (.lvl(lvl), .b_up(bu), .a_up(au), .b_lo(bl), .a_lo(al));
    reset_brownout_power_seq dut (.core_clk(core_clk), .sys_rst(sys_rst), .ext_reset_n(pin_n),
        .watchdog_timer_rst(wdt), .por_active(por), .vdd_below_upper(bu),
        .vdd_above_upper_hys(au), .vdd_below_lower(bl), .vdd_above_lower_hys(al),
        .osc_running(osc), .flash_init_done(fl), .dpd_request(dpd), .pd_active(pd),
        .rtc_alarm(alarm), .eint_in(eint), .eint_wake_en(een), .bod_irq_enable(irqen),
        .internal_rst(irst), .fetch_addr(fa), .use_internal_rc_oscillator(rc),
        .brownout_detector_irq(irq), .brownout_detector_status(st), .flash_access_ok(fok),
        .regulator_on(ron), .pd_wake(wk), .rtc_alarm_out(aout));
    task stop_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // bounded wait for release; a hang ends the run
    task wait_rel();
        int i;
        for (i = 0; i < 200 && irst !== 1'b0; i++)
            cyc(1);
        if (irst !== 1'b0)
        begin
            bad_count++;
            stop_test();
        end
        chk(fa, 32'h0000_0000);
    endtask
    task t_boot();
        wait_rel();
        chk(rc, 1'b1);
        chk(fok, 1'b0);
        cyc(FLASH_WAKE_CYC - 1);
        chk(fok, 1'b0);
        cyc(1);
        chk(fok, 1'b1);
        $display("boot done");
    endtask
    task t_src();
        int i;
        for (i = 0; i < 3; i++)
        begin
            @(posedge core_clk);
            {por, wdt, pin_n, osc, fl} <= {i == 2, i == 1, i != 0, 1'b0, 1'b1};
            cyc(6);
            chk(irst, 1'b1);
            @(posedge core_clk);
            {por, wdt, pin_n} <= 3'b001;
            cyc(40);
            chk(irst, 1'b1);
            @(posedge core_clk);
            {osc, fl} <= 2'b10;
            cyc(40);
            chk(irst, 1'b1);
            @(posedge core_clk);
            fl <= 1'b1;
            wait_rel();
        end
        $display("sources done");
    endtask
    task t_bod();
        @(posedge core_clk);
        lvl <= 2'h1;
        cyc(6);
        chk({st, irq, irst}, 3'b100);
        @(posedge core_clk);
        irqen <= 1'b1;
        cyc(1);
        chk(irq, 1'b1);
        @(posedge core_clk);
        lvl <= 2'h3;
        cyc(6);
        chk({st, irst}, 2'b10);
        @(posedge core_clk);
        lvl <= 2'h2;
        cyc(6);
        chk(irst, 1'b1);
        @(posedge core_clk);
        lvl <= 2'h0;
        wait_rel();
        chk(st, 1'b0);
        $display("brownout done");
    endtask
    task t_pwr();
        @(posedge core_clk);
        {pd, eint[2], een[2]} <= 3'b111;
        cyc(6);
        chk(wk, 1'b1);
        @(posedge core_clk);
        {pd, dpd} <= 2'b01;
        cyc(6);
        chk(ron, 1'b0);
        @(posedge core_clk);
        dpd <= 1'b0;
        cyc(6);
        chk(ron, 1'b0);
        @(posedge core_clk);
        alarm <= 1'b1;
        eint <= '0;
        een <= '0;
        cyc(6);
        chk(aout, 1'b1);
        @(posedge core_clk);
        alarm <= 1'b0;
        wait_rel();
        chk(ron, 1'b1);
        @(posedge core_clk);
        dpd <= 1'b1;
        cyc(6);
        chk(ron, 1'b0);
        @(posedge core_clk);
        {dpd, pin_n} <= 2'b00;
        cyc(6);
        chk({ron, irst}, 2'b11);
        @(posedge core_clk);
        pin_n <= 1'b1;
        wait_rel();
        $display("power done");
    endtask
    initial
    begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_boot();
        t_src();
        t_bod();
        t_pwr();
        stop_test();
    end
endmodule // reset_brownout_power_seq_tb_top
`default_nettype wire
